// >>> fan_lut_nine_pkg.sv
// Purpose: Shared constants for lookup-table entry nine
// Assumes: 8-bit register port, 7-bit register address
// Notes:   Offsets and reset values used by all design files
package fan_lut_nine_pkg;
    localparam logic [6:0] THRESH_NINE_ADDR  = 7'h60;
    localparam logic [6:0] DUTY_NINE_ADDR    = 7'h61;
    localparam logic [7:0] THRESH_NINE_RESET = 8'h7F;
    localparam logic [7:0] DUTY_NINE_RESET   = 8'h3F;
    localparam int         THRESH_TOP_POS    = 7;
    localparam int         DUTY_EXT_MSB      = 7;
    localparam int         DUTY_EXT_LSB      = 6;
    localparam logic [7:0] LOW_DUTY_MASK     = 8'h3F;
    localparam logic [7:0] LOW_THRESH_MASK   = 8'h7F;
endpackage

// >>> fan_lut_nine_regs.sv
// Purpose: Storage for the two entry-nine registers
// Assumes: One write per cycle, registered read data
// Notes:   Read data come out of a register
`timescale 1ns/10ps
module fan_lut_nine_regs
    import fan_lut_nine_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       wr_en,
    input  wire logic       wr_sel,
    input  wire logic [7:0] wr_data,
    input  wire logic       rd_sel,
    output logic      [7:0] rd_data,
    output logic      [7:0] thresh_q,
    output logic      [7:0] duty_q
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            thresh_q <= THRESH_NINE_RESET;
            duty_q   <= DUTY_NINE_RESET;
            rd_data  <= 8'h00;
        end else begin
            if (wr_en && !wr_sel)
                thresh_q <= wr_data;
            if (wr_en && wr_sel)
                duty_q <= wr_data;
            rd_data <= rd_sel ? duty_q : thresh_q;
        end
    end
endmodule

// >>> fan_lut_entry_nine.sv
// Purpose: Lookup-table entry nine of the fan speed controller
// Assumes: Temperature and mode inputs synchronous to clk_sys
// Notes:   Drives the duty when the remote temperature exceeds entry nine
// How it works
// - Low-res threshold: top bit reads zero
// - High-res threshold uses all eight bits
// - Range 0-127.5 half-steps, or 0-127
// - Above threshold, output entry-nine duty value
// - Compare nine bits high-res, eight low-res
// - Threshold sign bit always taken as zero
// - Lookup offset adds to programmed threshold
// - Low-res duty: top two bits read zero
// - High-res duty joins extended and low bits
// - Extended duty bits need high-frequency PWM
`timescale 1ns/10ps
module fan_lut_entry_nine
    import fan_lut_nine_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic [6:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic       write_unlock,
    input  wire logic       temp_hi_res,
    input  wire logic       duty_hi_res,
    input  wire logic       pwm_high_freq,
    input  wire logic [7:0] lut_temp_offset,
    input  wire logic [8:0] remote_temp,
    output logic      [7:0] reg_rdata,
    output logic            reg_hit,
    output logic            above_nine,
    output logic      [7:0] duty_nine
);
    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    function automatic logic is_entry(input logic [6:0] a);
        return (a == THRESH_NINE_ADDR) || (a == DUTY_NINE_ADDR);
    endfunction

    // Threshold bits kept in the given temperature mode
    function automatic logic [7:0] thresh_mask(input logic hi_res);
        return hi_res ? 8'hFF : LOW_THRESH_MASK;
    endfunction

    // Duty bits kept in the given duty mode
    function automatic logic [7:0] duty_mask(input logic hi_res);
        return hi_res ? 8'hFF : LOW_DUTY_MASK;
    endfunction

    // ----------------------------------------
    // Nets
    // ----------------------------------------
    wire        addr_hit;
    wire        wr_ok;
    wire        rd_ok;
    wire        sel_duty;
    wire  [7:0] raw_rd;
    wire  [7:0] thresh_raw;
    wire  [7:0] duty_raw;
    wire  [7:0] thresh_keep;
    wire  [7:0] duty_keep;
    wire  [7:0] thresh_view;
    wire  [7:0] duty_view;
    wire        threshold_nine_top_bit;
    wire  [6:0] threshold_nine_low_bits;
    wire  [1:0] duty_nine_extended_bits;
    wire  [5:0] duty_nine_low_bits;
    wire  [7:0] rd_keep;
    wire  [7:0] rd_masked;
    wire  [9:0] thr_hi;
    wire  [9:0] thr_lo;
    wire  [9:0] thr_half;
    wire  [9:0] off_half;
    wire [10:0] limit_sum;
    wire  [9:0] limit;
    wire  [9:0] temp_hi;
    wire  [9:0] temp_lo;
    wire  [9:0] temp_cmp;
    wire        exceeds;
    wire        ext_live;
    wire  [7:0] duty_short;
    wire  [7:0] duty_sel;
    wire        rd_sel_d;
    wire        rd_hit_d;
    wire        reg_hit_d;
    wire  [7:0] reg_rdata_d;
    wire        above_nine_d;
    wire  [7:0] duty_nine_d;
    logic       rd_sel_q;
    logic       rd_hit_q;

    // ----------------------------------------
    // Access qualifiers
    // ----------------------------------------
    assign addr_hit = is_entry(reg_addr);
    assign wr_ok    = reg_wr && addr_hit && write_unlock;
    assign rd_ok    = reg_rd && addr_hit;
    assign sel_duty = (reg_addr == DUTY_NINE_ADDR);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    fan_lut_nine_regs u_regs (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .wr_en    (wr_ok),
        .wr_sel   (sel_duty),
        .wr_data  (reg_wdata),
        .rd_sel   (sel_duty),
        .rd_data  (raw_rd),
        .thresh_q (thresh_raw),
        .duty_q   (duty_raw)
    );

    // ----------------------------------------
    // Field views
    // ----------------------------------------
    assign thresh_keep = thresh_mask(temp_hi_res);
    assign duty_keep   = duty_mask(duty_hi_res);

    generate
        for (genvar b = 0; b < 8; b++) begin : g_view
            assign thresh_view[b] = thresh_raw[b] & thresh_keep[b];
            assign duty_view[b]   = duty_raw[b] & duty_keep[b];
        end
    endgenerate

    assign threshold_nine_top_bit  = thresh_view[THRESH_TOP_POS];
    assign threshold_nine_low_bits = thresh_view[THRESH_TOP_POS-1:0];
    assign duty_nine_extended_bits = duty_view[DUTY_EXT_MSB:DUTY_EXT_LSB];
    assign duty_nine_low_bits      = duty_view[DUTY_EXT_LSB-1:0];

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    assign rd_keep   = rd_sel_q ? duty_mask(duty_hi_res) : thresh_mask(temp_hi_res);
    assign rd_masked = raw_rd & rd_keep;

    // ----------------------------------------
    // Threshold compare
    // ----------------------------------------
    // Half-degree units throughout; sign bit forced zero
    assign thr_hi    = {2'h0, thresh_view};
    assign thr_lo    = {2'h0, threshold_nine_low_bits, 1'h0};
    assign thr_half  = temp_hi_res ? thr_hi : thr_lo;
    assign off_half  = {1'h0, lut_temp_offset, 1'h0};
    assign limit_sum = {1'h0, thr_half} + {1'h0, off_half};
    assign limit     = limit_sum[9:0];
    assign temp_hi   = {1'h0, remote_temp};
    assign temp_lo   = {1'h0, remote_temp[8:1], 1'h0};
    assign temp_cmp  = temp_hi_res ? temp_hi : temp_lo;
    assign exceeds   = temp_cmp > limit;

    // ----------------------------------------
    // Duty value
    // ----------------------------------------
    assign ext_live   = duty_hi_res && pwm_high_freq;
    assign duty_short = {2'h0, duty_nine_low_bits};
    assign duty_sel   = ext_live ? duty_view : duty_short;

    // ----------------------------------------
    // Next values
    // ----------------------------------------
    assign rd_sel_d     = sel_duty;
    assign rd_hit_d     = rd_ok;
    assign reg_hit_d    = rd_hit_q;
    assign reg_rdata_d  = rd_hit_q ? rd_masked : 8'h00;
    assign above_nine_d = exceeds;
    assign duty_nine_d  = exceeds ? duty_sel : 8'h00;

    // ----------------------------------------
    // Pipeline and output registers
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_sel_q <= 1'h0;
        end else begin
            rd_sel_q <= rd_sel_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_hit_q <= 1'h0;
        end else begin
            rd_hit_q <= rd_hit_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_hit <= 1'h0;
        end else begin
            reg_hit <= reg_hit_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rdata_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            above_nine <= 1'h0;
        end else begin
            above_nine <= above_nine_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            duty_nine <= 8'h00;
        end else begin
            duty_nine <= duty_nine_d;
        end
    end
endmodule

// >>> fan_lut_entry_nine_props.sv
// Purpose: Assertions on the entry-nine ports
// Assumes: One clock domain, async active-low reset
// Notes:   Bound to every instance of the block
`timescale 1ns/10ps
module fan_lut_entry_nine_props
    import fan_lut_nine_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic [6:0] reg_addr,
    input wire logic       reg_rd,
    input wire logic       temp_hi_res,
    input wire logic       duty_hi_res,
    input wire logic       pwm_high_freq,
    input wire logic [8:0] remote_temp,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_hit,
    input wire logic       above_nine,
    input wire logic [7:0] duty_nine
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_hit_latency: assert property (reg_rd && (reg_addr == THRESH_NINE_ADDR || reg_addr == DUTY_NINE_ADDR)
        |-> ##2 reg_hit) else $error("late");
    a_no_stray: assert property (reg_hit |-> $past(reg_rd, 2)) else $error("stray answer");
    a_rdata_idle: assert property (!reg_hit |-> reg_rdata == 8'h00) else $error("rdata not zero");
    a_thresh_top: assert property (reg_hit && $past(reg_addr, 2) == THRESH_NINE_ADDR && !$past(temp_hi_res)
        |-> !reg_rdata[7]) else $error("threshold bit 7 set");
    a_duty_top: assert property (reg_hit && $past(reg_addr, 2) == DUTY_NINE_ADDR && !$past(duty_hi_res)
        |-> reg_rdata[7:6] == 2'h0) else $error("duty bits set");
    a_duty_idle: assert property (!above_nine |-> duty_nine == 8'h00) else $error("duty not zero");
    a_ext_gate: assert property (!$past(pwm_high_freq) |-> duty_nine[7:6] == 2'h0) else $error("ext");
    a_zero_temp: assert property ($past(remote_temp) == 9'h000 |-> !above_nine) else $error("zero");
    c_hit: cover property (reg_hit && reg_rdata[7]);
    c_above: cover property (above_nine);
    c_ext: cover property (duty_nine[7]);
endmodule
bind fan_lut_entry_nine fan_lut_entry_nine_props i_fan_lut_entry_nine_props (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .reg_addr      (reg_addr),
    .reg_rd        (reg_rd),
    .temp_hi_res   (temp_hi_res),
    .duty_hi_res   (duty_hi_res),
    .pwm_high_freq (pwm_high_freq),
    .remote_temp   (remote_temp),
    .reg_rdata     (reg_rdata),
    .reg_hit       (reg_hit),
    .above_nine    (above_nine),
    .duty_nine     (duty_nine)
);

// >>> fan_lut_entry_nine_tb.sv
// Purpose: Random self-checking bench for entry nine
// Assumes: Inputs change at the falling edge
// Notes:   Model keeps the raw stored bytes
`timescale 1ns/10ps
module fan_lut_entry_nine_tb;
    import fan_lut_nine_pkg::*;
    logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, write_unlock = 0, temp_hi_res = 0;
    logic duty_hi_res = 0, pwm_high_freq = 0, reg_hit, above_nine, ab;
    logic [6:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, lut_temp_offset = 0, reg_rdata, duty_nine, wd;
    logic [7:0] th = THRESH_NINE_RESET, du = DUTY_NINE_RESET;
    logic [8:0] remote_temp = 0;
    int bad_count = 0, n_compared = 0, seed = 16976;
    fan_lut_entry_nine i_fan_lut_entry_nine (
        .clk_sys         (clk_sys),
        .rst_n           (rst_n),
        .reg_addr        (reg_addr),
        .reg_wdata       (reg_wdata),
        .reg_wr          (reg_wr),
        .reg_rd          (reg_rd),
        .write_unlock    (write_unlock),
        .temp_hi_res     (temp_hi_res),
        .duty_hi_res     (duty_hi_res),
        .pwm_high_freq   (pwm_high_freq),
        .lut_temp_offset (lut_temp_offset),
        .remote_temp     (remote_temp),
        .reg_rdata       (reg_rdata),
        .reg_hit         (reg_hit),
        .above_nine      (above_nine),
        .duty_nine       (duty_nine)
    );
    initial forever #5 clk_sys = ~clk_sys;
    function automatic logic [8:0] lim();
        return (temp_hi_res ? {1'b0, th} : {1'b0, th[6:0], 1'b0}) + {lut_temp_offset, 1'b0};
    endfunction
    task automatic chk(logic [8:0] s, logic [8:0] e);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic acc(logic w, logic [6:0] a, logic [7:0] d);
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 0;
        reg_rd = 0;
    endtask
    task automatic rd(logic [6:0] a, logic [7:0] e);
        acc(0, a, 8'h00);
        @(negedge clk_sys);
        chk(reg_hit, 1);
        chk(reg_rdata, e);
    endtask
    task automatic end_sim;
        $display("compared %0d errors %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #400000;
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (20) @(negedge clk_sys);
        rst_n = 1;
        rd(THRESH_NINE_ADDR, th & LOW_THRESH_MASK);
        rd(DUTY_NINE_ADDR, du & LOW_DUTY_MASK);
        for (int i = 0; i < 400; i++) begin
            if (i == 200) begin
                rst_n = 0;
                @(negedge clk_sys);
                chk(above_nine, 0);
                chk(duty_nine, 0);
                chk(reg_hit, 0);
                th = THRESH_NINE_RESET;
                du = DUTY_NINE_RESET;
                rst_n = 1;
            end
            {write_unlock, temp_hi_res, duty_hi_res, pwm_high_freq} = 4'($random(seed));
            lut_temp_offset = 8'($random(seed)) & 8'h7F;
            wd = 8'($random(seed));
            acc(1, THRESH_NINE_ADDR + 7'(i[1]), wd);
            if (write_unlock && i[1]) du = wd;
            if (write_unlock && !i[1]) th = wd;
            remote_temp = i[0] ? lim() + 9'(i[2]) : 9'($random(seed));
            ab = (temp_hi_res ? remote_temp : {remote_temp[8:1], 1'b0}) > lim();
            @(negedge clk_sys);
            chk(above_nine, ab);
            chk(duty_nine, ab ? (duty_hi_res && pwm_high_freq ? du : du & LOW_DUTY_MASK) : 8'h00);
            rd(THRESH_NINE_ADDR, temp_hi_res ? th : th & LOW_THRESH_MASK);
            rd(DUTY_NINE_ADDR, duty_hi_res ? du : du & LOW_DUTY_MASK);
            if (i[2:0] == 3'h5) begin
                acc(1, 7'h5F + 7'(i[3]) * 7'h04, 8'hFF);
                @(negedge clk_sys);
                acc(0, 7'h5F + 7'(i[3]) * 7'h04, 8'h00);
                @(negedge clk_sys);
                chk(reg_hit, 0);
                chk(reg_rdata, 0);
            end
        end
        end_sim();
    end
endmodule
